// File: src/mode_reg_params.svh
// Bit positions, codes and counts for the mode register 2 and 3 block.
`ifndef MODE_REG_PARAMS_SVH
`define MODE_REG_PARAMS_SVH

// Mode register width and the address pins that load it.
`define MR_W 18
`define ADDR_W 14
`define BA_W 3

// Bank address codes that select the two registers.
`define BA_SEL_MR2 3'h2
`define BA_SEL_MR3 3'h3

// Field positions of the write latency, refresh and termination register.
`define CWL_MSB 5
`define CWL_LSB 3
`define ASR_BIT 6
`define SRT_BIT 7
`define RTT_WR_MSB 10
`define RTT_WR_LSB 9
`define RTT_WR_OFF 2'h0

// Field positions of the calibration readout register.
`define MPR_EN_BIT 2
`define MPR_SEL_MSB 1
`define MPR_SEL_LSB 0
`define MPR_SEL_PATTERN 2'h0

// Read address bits that pick burst chop and the nibble.
`define A_BC_BIT 12
`define A_NIB_BIT 2

// Write latency coding: lowest code is five clocks, top code is reserved.
`define CWL_BASE 4'h5
`define CWL_CODE_RSVD 3'h7

// Calibration pattern, burst bit 0 in the least significant bit.
`define MPR_PATTERN 8'hAA

// Clock counts of a data burst on the link.
`define BL8_CLOCKS 5'h04
`define BC4_CLOCKS 5'h02

// Reset value of both registers.
`define MR_RESET 18'h00000

`endif

// File: src/mode_reg_pkg.sv
// Types shared by the mode register 2 and 3 block.
package mode_reg_pkg;

    // One command word as seen on the link at a clock edge.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } ddr_cmd_s;

    // Termination applied to the data pins.
    typedef enum logic [1:0] {RTT_HIZ, RTT_NOM, RTT_WR} rtt_e;

    // Progress of a write burst for the termination switch.
    typedef enum logic [1:0] {W_IDLE, W_WAIT, W_BURST} wr_state_e;

endpackage

// File: src/sig_sync.sv
// Two flip-flop synchroniser for a group of pins.
`timescale 1ns/1ps
module sig_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Asynchronous pins and their synchronised copy.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_r; // First stage, read only by the second stage.
    logic [W-1:0] sync_r; // Second stage, safe to use.

    // Both stages clear on reset and then shift the pins in.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // sig_sync

// File: src/mode_reg23.sv
// Mode registers 2 and 3: write latency, self refresh rate, write termination and calibration readout.
//
// Contract
// [R1] Register 2 holds until reloaded; array untouched.
// [R2] Controller loads only idle, then waits.
// [R3] Controller writes zero to register 2 reserved bits.
// [R4] Bits 5:3 select CAS write latency.
// [R5] Write latency is CWL plus additive latency.
// [R6] Auto mode doubles refresh rate when hot.
// [R7] Temperature mode forces double refresh rate.
// [R8] Both modes off gives single refresh rate.
// [R9] Controller never sets both refresh modes.
// [R10] Extended range needs double refresh, one mode.
// [R11] Bits 10:9 select write termination, nonzero enables.
// [R12] Write termination spans each write burst only; a write arriving while another write is in its wait or burst gets none.
// [R13] Nominal off means high impedance outside writes.
// [R14] No write termination during write leveling.
// [R15] Register 3 holds until reloaded; array untouched.
// [R16] Controller writes zero to register 3 reserved bits.
// [R17] Bit 2 clear: normal reads, mode ignored.
// [R18] Bit 2 set: reads return calibration data.
// [R19] Controller precharges all banks before enabling readout.
// [R20] Controller issues only reads during readout mode.
// [R21] Reset works while readout mode is on.
// [R22] Readout may be repeated by successive reads.
// [R23] Calibration pattern is alternating 01010101.
// [R24] Bank code 010 loads 2, 011 loads 3.
// [R25] Lowest latency code is five, reserved illegal.
// [R26] New settings act within tMOD of loading.
`timescale 1ns/1ps
module mode_reg23
    import mode_reg_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Command bus from the controller, on the link clock.
    input wire logic ck_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [2:0] ba_i,
    input wire logic [13:0] addr_i,
    // Case temperature sensor, asynchronous.
    input wire logic temp_hot_i,
    // Settings from the other mode registers, same clock.
    input wire logic [3:0] al_cycles_i,
    input wire logic write_level_i,
    input wire logic rtt_nom_en_i,
    // Decoded write latency.
    output logic [3:0] cwl_cycles_o,
    output logic cwl_illegal_o,
    output logic [4:0] wl_cycles_o,
    // Self refresh rate and termination.
    output logic sr_rate_2x_o,
    output logic [1:0] rtt_wr_code_o,
    output rtt_e rtt_sel_o,
    // Calibration readout.
    output logic mpr_en_o,
    output logic [1:0] mpr_mode_o,
    output logic rd_array_o,
    output logic rd_mpr_o,
    output logic [7:0] mpr_data_o
);

`include "mode_reg_params.svh"

    // Calibration pattern held as a constant so that its nibbles can be selected.
    localparam logic [7:0] mpr_pat = `MPR_PATTERN;

    // Decodes the write latency code into clocks; the reserved code gives zero.
    function automatic logic [3:0] cwl_decode(input logic [2:0] code);
        if (code == `CWL_CODE_RSVD) begin
            cwl_decode = 4'h0;
        end else begin
            cwl_decode = `CWL_BASE + {1'b0, code};
        end
    endfunction

    // Synchronised link pins and the edge finder on the link clock.
    ddr_cmd_s cmd_pin; // Raw command pins gathered.
    ddr_cmd_s cmd_s; // Command after the synchroniser.
    logic ck_s; // Link clock after the synchroniser.
    logic hot_s; // Temperature flag after the synchroniser.
    logic ck_d_r; // Previous link clock level.
    logic ck_rise; // Rising edge of the link clock.

    assign cmd_pin = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i, ba: ba_i, addr: addr_i};

    // Every pin from the controller and sensor passes two flops first.
    sig_sync #(.W($bits(ddr_cmd_s) + 2)) i_sig_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({ck_i, temp_hot_i, cmd_pin}),
        .sync_o({ck_s, hot_s, cmd_s})
    );

    assign ck_rise = ck_s & ~ck_d_r;

    // Command decode at the link clock edge.
    logic is_cmd; // A selected device on a clock edge.
    logic is_mrs; // Mode register set.
    logic is_read; // Read or read with auto precharge.
    logic is_write; // Write or write with auto precharge.
    logic mr2_load; // Load of register 2.
    logic mr3_load; // Load of register 3.

    assign is_cmd = ck_rise & ~cmd_s.cs_n;
    assign is_mrs = is_cmd & ~cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;
    assign is_read = is_cmd & cmd_s.ras_n & ~cmd_s.cas_n & cmd_s.we_n;
    assign is_write = is_cmd & cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;
    assign mr2_load = is_mrs & (cmd_s.ba == `BA_SEL_MR2); // [R24]
    assign mr3_load = is_mrs & (cmd_s.ba == `BA_SEL_MR3); // [R24]

    // Register state and its next values.
    logic [`MR_W-1:0] mr2_r, mr2_nxt; // Write latency, refresh and termination.
    logic [`MR_W-1:0] mr3_r, mr3_nxt; // Calibration readout.

    // A load copies the address pins; bits above them stay zero.
    always_comb begin
        mr2_nxt = mr2_r; // [R1]
        mr3_nxt = mr3_r; // [R15]
        if (mr2_load) begin
            mr2_nxt = {4'h0, cmd_s.addr}; // [R1]
        end
        if (mr3_load) begin
            mr3_nxt = {4'h0, cmd_s.addr}; // [R15]
        end
    end

    // Reset clears both registers, also with readout enabled; the link clock level feeds the edge finder.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mr2_r <= `MR_RESET;
            mr3_r <= `MR_RESET; // [R21]
            ck_d_r <= 1'b0;
        end else begin
            mr2_r <= mr2_nxt;
            mr3_r <= mr3_nxt;
            ck_d_r <= ck_s;
        end
    end

    // Fields used by the decode logic.
    logic [2:0] cwl_code; // Latency code.
    logic asr_en; // Automatic refresh rate.
    logic srt_en; // Forced double refresh rate.
    logic [1:0] rtt_wr_code; // Write termination value.
    logic dyn_odt_en; // Write termination selected.
    logic mpr_en; // Readout replaces array reads.
    logic [1:0] mpr_mode; // Readout mode.

    assign cwl_code = mr2_r[`CWL_MSB:`CWL_LSB]; // [R4]
    assign asr_en = mr2_r[`ASR_BIT];
    assign srt_en = mr2_r[`SRT_BIT];
    assign rtt_wr_code = mr2_r[`RTT_WR_MSB:`RTT_WR_LSB];
    assign dyn_odt_en = (rtt_wr_code != `RTT_WR_OFF); // [R11]
    assign mpr_en = mr3_r[`MPR_EN_BIT];
    assign mpr_mode = mr3_r[`MPR_SEL_MSB:`MPR_SEL_LSB];

    // Write burst tracking for the termination switch.
    wr_state_e wst_r, wst_nxt; // Burst phase.
    logic [4:0] wcnt_r, wcnt_nxt; // Link clocks left in the phase.
    logic wbl8_r, wbl8_nxt; // Burst length of the tracked write, kept from its command.
    logic [4:0] wl_now; // Current total write latency.

    assign wl_now = {1'b0, cwl_decode(cwl_code)} + {1'b0, al_cycles_i}; // [R5]

    // A write waits out the latency, then holds for the burst length in link clocks.
    always_comb begin
        wst_nxt = wst_r;
        wcnt_nxt = wcnt_r;
        wbl8_nxt = wbl8_r;
        case (wst_r)
            W_IDLE: begin
                if (is_write) begin
                    wst_nxt = W_WAIT; // [R12]
                    wcnt_nxt = wl_now;
                    wbl8_nxt = cmd_s.addr[`A_BC_BIT];
                end
            end
            W_WAIT: begin
                // Counts link edges until the first data is latched.
                if (ck_rise) begin
                    if (wcnt_r <= 5'h01) begin
                        wst_nxt = W_BURST; // [R12]
                        wcnt_nxt = wbl8_r ? `BL8_CLOCKS : `BC4_CLOCKS;
                    end else begin
                        wcnt_nxt = wcnt_r - 5'h01;
                    end
                end
            end
            W_BURST: begin
                // The burst ends and nominal termination or high impedance returns.
                if (ck_rise) begin
                    if (wcnt_r <= 5'h01) begin
                        wst_nxt = W_IDLE; // [R12]
                        wcnt_nxt = 5'h00;
                    end else begin
                        wcnt_nxt = wcnt_r - 5'h01;
                    end
                end
            end
            default: begin
                wst_nxt = W_IDLE;
                wcnt_nxt = 5'h00;
            end
        endcase
    end

    // Registers the burst phase.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wst_r <= W_IDLE;
            wcnt_r <= 5'h00;
            wbl8_r <= 1'b0;
        end else begin
            wst_r <= wst_nxt;
            wcnt_r <= wcnt_nxt;
            wbl8_r <= wbl8_nxt;
        end
    end

    // Output values computed from the registers.
    ddr_cmd_s rd_cmd; // Command of the current read.
    rtt_e rtt_nxt; // Termination choice.
    logic sr2x_nxt; // Refresh rate choice.
    logic [7:0] mpr_data_nxt; // Readout data.

    assign rd_cmd = cmd_s;

    // Refresh rate, termination and readout data, all settled two clocks after a load.
    always_comb begin
        // Forced mode doubles always, auto mode only when hot, else single rate.
        sr2x_nxt = srt_en | (asr_en & hot_s); // [R6] [R7] [R8]
        // Nominal termination or high impedance outside write bursts.
        rtt_nxt = rtt_nom_en_i ? RTT_NOM : RTT_HIZ; // [R13]
        if ((wst_r == W_BURST) && dyn_odt_en && !write_level_i) begin
            rtt_nxt = RTT_WR; // [R12] [R14]
        end
        // Calibration pattern, one nibble for a chopped burst.
        mpr_data_nxt = mpr_data_o; // [R22]
        if (is_read && mpr_en) begin
            if (mpr_mode != `MPR_SEL_PATTERN) begin
                mpr_data_nxt = 8'h00;
            end else if (rd_cmd.addr[`A_BC_BIT]) begin
                mpr_data_nxt = `MPR_PATTERN; // [R23]
            end else if (rd_cmd.addr[`A_NIB_BIT]) begin
                mpr_data_nxt = {4'h0, mpr_pat[7:4]};
            end else begin
                mpr_data_nxt = {4'h0, mpr_pat[3:0]};
            end
        end
    end

    // Registers every output so that it stands from reset onward.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cwl_cycles_o <= 4'h0;
            cwl_illegal_o <= 1'b0;
            wl_cycles_o <= 5'h00;
            sr_rate_2x_o <= 1'b0;
            rtt_wr_code_o <= 2'h0;
            rtt_sel_o <= RTT_HIZ;
            mpr_en_o <= 1'b0;
            mpr_mode_o <= 2'h0;
            rd_array_o <= 1'b0;
            rd_mpr_o <= 1'b0;
            mpr_data_o <= 8'h00;
        end else begin
            cwl_cycles_o <= cwl_decode(cwl_code); // [R4] [R25] [R26]
            cwl_illegal_o <= (cwl_code == `CWL_CODE_RSVD); // [R25]
            wl_cycles_o <= wl_now; // [R5]
            sr_rate_2x_o <= sr2x_nxt;
            rtt_wr_code_o <= rtt_wr_code; // [R11]
            rtt_sel_o <= rtt_nxt;
            mpr_en_o <= mpr_en;
            mpr_mode_o <= mpr_en ? mpr_mode : 2'h0; // [R17]
            rd_array_o <= is_read & ~mpr_en; // [R17]
            rd_mpr_o <= is_read & mpr_en; // [R18] [R22]
            mpr_data_o <= mpr_data_nxt;
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_mr2_hold;
        !mr2_load |=> mr2_r == $past(mr2_r);
    endproperty
    a_mr2_hold: assert property (p_mr2_hold) else $error("Register 2 changed without a load."); // [R1]

    property p_mr3_hold;
        !mr3_load |=> mr3_r == $past(mr3_r);
    endproperty
    a_mr3_hold: assert property (p_mr3_hold) else $error("Register 3 changed without a load."); // [R15]

    property p_mr2_load;
        mr2_load |=> mr2_r[`ADDR_W-1:0] == $past(cmd_s.addr) ##1 cwl_cycles_o == cwl_decode(mr2_r[`CWL_MSB:`CWL_LSB]);
    endproperty
    a_mr2_load: assert property (p_mr2_load) else $error("Register 2 load not applied."); // [R24] [R26]

    property p_cwl_low;
        mr2_load && cmd_s.addr[`CWL_MSB:`CWL_LSB] == 3'h0 |-> ##2 cwl_cycles_o == `CWL_BASE && !cwl_illegal_o;
    endproperty
    a_cwl_low: assert property (p_cwl_low) else $error("Lowest latency code is not five clocks."); // [R25]

    property p_wl_sum;
        $stable(al_cycles_i) && $stable(mr2_r) |=> wl_cycles_o == cwl_cycles_o + {1'b0, $past(al_cycles_i)};
    endproperty
    a_wl_sum: assert property (p_wl_sum) else $error("Write latency is not CWL plus AL."); // [R5]

    property p_srt;
        srt_en |=> sr_rate_2x_o;
    endproperty
    a_srt: assert property (p_srt) else $error("Forced mode did not double refresh."); // [R7]

    property p_asr;
        asr_en && hot_s |=> sr_rate_2x_o;
    endproperty
    a_asr: assert property (p_asr) else $error("Auto mode did not double refresh when hot."); // [R6]

    property p_single;
        !srt_en && !asr_en |=> !sr_rate_2x_o;
    endproperty
    a_single: assert property (p_single) else $error("Refresh doubled with both modes off."); // [R8]

    property p_wr_term;
        rtt_sel_o == RTT_WR |-> $past(wst_r) == W_BURST && rtt_wr_code_o != 2'h0;
    endproperty
    a_wr_term: assert property (p_wr_term) else $error("Write termination outside a burst."); // [R11] [R12] [R13]

    property p_wlevel;
        write_level_i |=> rtt_sel_o != RTT_WR;
    endproperty
    a_wlevel: assert property (p_wlevel) else $error("Write termination during leveling."); // [R14]

    property p_normal_read;
        is_read && !mpr_en |=> rd_array_o && !rd_mpr_o;
    endproperty
    a_normal_read: assert property (p_normal_read) else $error("Normal read redirected."); // [R17]

    property p_mpr_read;
        is_read && mpr_en && mpr_mode == `MPR_SEL_PATTERN && rd_cmd.addr[`A_BC_BIT] |=> rd_mpr_o && mpr_data_o == mpr_pat;
    endproperty
    a_mpr_read: assert property (p_mpr_read) else $error("Calibration read returned wrong data."); // [R18] [R23]

endmodule // mode_reg23

// File: verif/ddr_ctrl_model.sv
// Behavioural memory controller that frames commands on the link clock.
`timescale 1ns/1ps
`include "mode_reg_params.svh"
module ddr_ctrl_model (
    // Bench clock that paces the frames.
    input wire logic sys_clk_i,
    // Command bus toward the device.
    output logic ck_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [2:0] ba_o,
    output logic [13:0] addr_o
);
    // The link clock stands low and the device is deselected until the first frame.
    initial begin
        ck_o = 1'b0;
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = 3'h7;
        ba_o = 3'h7;
        addr_o = 14'h3FFF;
    end

    // One frame of 160 ns: the pins settle, the link clock rises mid-frame and falls again.
    task automatic frame(input logic [3:0] cmd_n, input logic [2:0] ba, input logic [13:0] addr);
        @(negedge sys_clk_i);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_n;
        ba_o = ba;
        addr_o = addr;
        repeat (4) @(negedge sys_clk_i);
        ck_o = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        ck_o = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        // Deselect and invert the rest so stale pins never pass for a command.
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = {1'b1, ~cmd_n[2:0]};
        ba_o = ~ba;
        addr_o = ~addr;
    endtask

    // Mode load with reserved positions forced to zero; frames keep the command spacing.
    task automatic mrs(input logic [2:0] ba, input logic [13:0] addr);
        logic [13:0] keep;
        keep = (ba == `BA_SEL_MR2) ? 14'h06F8 : (ba == `BA_SEL_MR3) ? 14'h0007 : 14'h3FFF;
        frame(4'h0, ba, addr & keep);
    endtask

    // Read with burst length and nibble selection.
    task automatic rd(input logic bl8, input logic nib);
        logic [13:0] a;
        a = 14'h0000;
        a[`A_BC_BIT] = bl8;
        a[`A_NIB_BIT] = nib;
        frame(4'h5, 3'h0, a);
    endtask

    // Write with burst length selection.
    task automatic wr(input logic bl8);
        logic [13:0] a;
        a = 14'h0000;
        a[`A_BC_BIT] = bl8;
        frame(4'h4, 3'h0, a);
    endtask

    // Precharge of all banks before readout is enabled.
    task automatic pre_all();
        frame(4'h2, 3'h0, 14'h0400);
    endtask

    // Deselect frames that keep the link clock running.
    task automatic nop(input int n);
        repeat (n) frame(4'hF, 3'h0, 14'h0000);
    endtask
endmodule // ddr_ctrl_model

// File: verif/mode_reg23_test.sv
// Self-checking bench for the mode register 2 and 3 block.
`timescale 1ns/1ps
`include "mode_reg_params.svh"
module mode_reg23_test
    import mode_reg_pkg::*;
;
    logic sys_clk, rst_n, ck, cs_n, ras_n, cas_n, we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic temp_hot, write_level, rtt_nom_en;
    logic [3:0] al_cycles, cwl_cycles;
    logic cwl_illegal, sr_rate_2x, mpr_en, rd_array, rd_mpr;
    logic [4:0] wl_cycles;
    logic [1:0] rtt_wr_code, mpr_mode;
    rtt_e rtt_sel;
    logic [7:0] mpr_data;
    int bad_count = 0;
    int cmp_count = 0;
    int arr_cnt = 0;
    int mpr_cnt = 0;
    // Refresh table: auto mode, forced mode, hot case, expected double rate.
    logic [3:0] rf [5] = '{4'h0, 4'h8, 4'hB, 4'h5, 4'h7};

    mode_reg23 i_mode_reg23 (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ck_i(ck), .cs_n_i(cs_n), .ras_n_i(ras_n),
        .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .temp_hot_i(temp_hot),
        .al_cycles_i(al_cycles), .write_level_i(write_level), .rtt_nom_en_i(rtt_nom_en),
        .cwl_cycles_o(cwl_cycles), .cwl_illegal_o(cwl_illegal), .wl_cycles_o(wl_cycles),
        .sr_rate_2x_o(sr_rate_2x), .rtt_wr_code_o(rtt_wr_code), .rtt_sel_o(rtt_sel), .mpr_en_o(mpr_en),
        .mpr_mode_o(mpr_mode), .rd_array_o(rd_array), .rd_mpr_o(rd_mpr), .mpr_data_o(mpr_data));
    ddr_ctrl_model i_ddr_ctrl_model (.sys_clk_i(sys_clk), .ck_o(ck), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // One-cycle read pulses are counted at every falling edge, where they have settled.
    always @(negedge sys_clk) begin
        if (rd_array === 1'b1) arr_cnt++;
        if (rd_mpr === 1'b1) mpr_cnt++;
    end

    // Comparison of one seen value against its expectation.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Expected latency in clocks for a latency code; the top code is reserved.
    function automatic logic [3:0] cwl_exp(input logic [2:0] c);
        return (c == `CWL_CODE_RSVD) ? 4'h0 : `CWL_BASE + {1'b0, c};
    endfunction

    // Register 2 word from its fields.
    function automatic logic [13:0] mr2(input logic [2:0] c, input logic asr, input logic srt, input logic [1:0] r);
        logic [13:0] w;
        w = 14'h0000;
        w[`CWL_MSB:`CWL_LSB] = c;
        w[`ASR_BIT] = asr;
        w[`SRT_BIT] = srt;
        w[`RTT_WR_MSB:`RTT_WR_LSB] = r;
        return w;
    endfunction

    // Write burst: termination before, during and after the burst phase.
    task automatic write_check(input logic bl8, input rtt_e idle, input rtt_e busy);
        i_ddr_ctrl_model.wr(bl8);
        i_ddr_ctrl_model.nop(4);
        check({6'h0, rtt_sel}, {6'h0, idle});
        i_ddr_ctrl_model.nop(1);
        check({6'h0, rtt_sel}, {6'h0, busy});
        i_ddr_ctrl_model.nop(bl8 ? 3 : 1);
        check({6'h0, rtt_sel}, {6'h0, busy});
        i_ddr_ctrl_model.nop(1);
        check({6'h0, rtt_sel}, {6'h0, idle});
    endtask

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        temp_hot = 1'b0;
        al_cycles = 4'h3;
        write_level = 1'b0;
        rtt_nom_en = 1'b1;
        repeat (8) @(negedge sys_clk);
        check({cwl_cycles, mpr_en, sr_rate_2x, rtt_sel}, 8'h00);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        // Every latency and termination code, with an additive latency of three.
        for (int c = 0; c < 8; c++) begin
            i_ddr_ctrl_model.mrs(`BA_SEL_MR2, mr2(3'(c), 1'b0, 1'b0, 2'(c)));
            check({4'h0, cwl_cycles}, {4'h0, cwl_exp(3'(c))});
            check({7'h0, cwl_illegal}, {7'h0, c == 7});
            if (c != 7) check({3'h0, wl_cycles}, {3'h0, cwl_exp(3'(c)) + 5'h03});
            check({6'h0, rtt_wr_code}, {6'h0, 2'(c)});
        end
        al_cycles = 4'h0;
        // Refresh rate cases; both modes are never set together, and a hot case always has one.
        for (int i = 0; i < 5; i++) begin
            temp_hot = rf[i][1];
            i_ddr_ctrl_model.mrs(`BA_SEL_MR2, mr2(3'h0, rf[i][3], rf[i][2], 2'h1));
            check({7'h0, sr_rate_2x}, {7'h0, rf[i][0]});
        end
        temp_hot = 1'b0;
        // Termination around write bursts, latency five clocks.
        write_check(1'b1, RTT_NOM, RTT_WR);
        rtt_nom_en = 1'b0;
        write_check(1'b0, RTT_HIZ, RTT_WR);
        write_level = 1'b1;
        write_check(1'b1, RTT_HIZ, RTT_HIZ);
        write_level = 1'b0;
        rtt_nom_en = 1'b1;
        i_ddr_ctrl_model.mrs(`BA_SEL_MR2, mr2(3'h0, 1'b0, 1'b0, `RTT_WR_OFF));
        write_check(1'b1, RTT_NOM, RTT_NOM);
        // Calibration readout; only reads and mode loads while it is enabled.
        i_ddr_ctrl_model.pre_all();
        i_ddr_ctrl_model.mrs(`BA_SEL_MR3, 14'h0004);
        check({mpr_en, mpr_mode, cwl_cycles}, {3'h4, `CWL_BASE});
        // Full bursts alternate with the lower and then the upper nibble of a chopped burst.
        for (int i = 0; i < 4; i++) begin
            i_ddr_ctrl_model.rd(i[0] == 1'b0, i == 3);
            check(mpr_data, (i[0] == 1'b1) ? 8'h0A : `MPR_PATTERN);
        end
        i_ddr_ctrl_model.mrs(`BA_SEL_MR3, 14'h0005);
        check({6'h0, mpr_mode}, 8'h01);
        i_ddr_ctrl_model.rd(1'b1, 1'b0);
        check(mpr_data, 8'h00);
        check(mpr_cnt[7:0], 8'h05);
        // Normal mode ignores the mode bits and reads the array.
        i_ddr_ctrl_model.mrs(`BA_SEL_MR3, 14'h0003);
        check({5'h0, mpr_en, mpr_mode}, 8'h00);
        i_ddr_ctrl_model.rd(1'b1, 1'b0);
        check(arr_cnt[7:0], 8'h01);
        check(mpr_cnt[7:0], 8'h05);
        // Loads to the other bank codes leave both registers alone.
        for (int b = 0; b < 8; b++) begin
            if (b != 2 && b != 3) i_ddr_ctrl_model.mrs(3'(b), 14'h0604);
        end
        check({mpr_en, rtt_wr_code, 1'b0, cwl_cycles}, {4'h0, `CWL_BASE});
        // Reset in the middle of readout mode, then the registers start over.
        i_ddr_ctrl_model.pre_all();
        i_ddr_ctrl_model.mrs(`BA_SEL_MR3, 14'h0004);
        check({7'h0, mpr_en}, 8'h01);
        rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check({mpr_en, cwl_cycles, 3'h0}, 8'h00);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({mpr_en, 3'h0, cwl_cycles}, {4'h0, `CWL_BASE});
        test_done();
    end

    // Watchdog well beyond the expected run of about 11 us.
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule // mode_reg23_test
